// ---- bench/serial_peer.sv ----
// Purpose: remote serial transceiver on data and clock lines
// Assumes: tasks called from the bench, one transfer at a time
// Notes: slave clock runs only while a transfer is under way
`timescale 1ns/1ps
module serial_peer (
  input wire logic clk_sys_i,
  input wire logic txd_i,
  input wire logic xck_i,
  output logic rxd_o,
  output logic xck_o
);
  logic run = 1'b0;
  initial rxd_o = 1'b1;
  initial xck_o = 1'b0;
  // Period of 16 system clocks keeps well under a quarter of it
  always begin
    repeat (8) @(posedge clk_sys_i);
    xck_o <= run ? !xck_o : 1'b0;
  end
  task automatic edge_wait(input logic smp, input logic pol);
    if (smp ^ pol) @(negedge xck_i);
    else @(posedge xck_i);
  endtask : edge_wait
  task automatic grab(input int n, bc, input logic sy, pol,
                      output logic [12:0] f);
    f = '0;
    run = sy;
    if (sy) do edge_wait(1'b1, pol); while (txd_i !== 1'b0);
    else @(negedge txd_i);
    if (!sy) repeat (bc / 2) @(posedge clk_sys_i);
    f[0] = txd_i;
    for (int k = 1; k < n; k++) begin
      if (sy) edge_wait(1'b1, pol);
      else repeat (bc) @(posedge clk_sys_i);
      f[k] = txd_i;
    end
    run = 1'b0;
  endtask : grab
  task automatic put(input int n, bc, input logic sy, pol,
                     input logic [12:0] f);
    run = sy;
    for (int k = 0; k < n; k++) begin
      if (sy) edge_wait(1'b0, pol);
      rxd_o <= f[k];
      if (!sy) repeat (bc) @(posedge clk_sys_i);
    end
    if (sy) edge_wait(1'b0, pol);
    run = 1'b0;
    rxd_o <= 1'b1;
  endtask : put
endmodule : serial_peer

// ---- bench/tb_usart_clock_and_frame_format.sv ----
// Purpose: self-checking bench of the serial port clock and frames
// Assumes: peer model on the data and transfer clock lines
// Notes: six formats cover all sizes, parity codes and clock modes
`timescale 1ns/1ps
`include "ucf_defines.svh"
module tb_usart_clock_and_frame_format;
  logic clk_sys_i, nrst_i, wr_i, rd_i, rxd, txd, xck_o, oe_n, pxck, xck;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  int errors = 0;
  int checks_done = 0;
  assign xck = oe_n ? pxck : xck_o;
  usart_clock_and_frame_format dut (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .serial_receive_pin_i(rxd),
    .serial_transmit_pin_o(txd), .transfer_clock_pin_i(xck),
    .transfer_clock_pin_o(xck_o), .transfer_clock_pin_oe_n_o(oe_n));
  serial_peer peer (.clk_sys_i(clk_sys_i), .txd_i(txd), .xck_i(xck),
    .rxd_o(rxd), .xck_o(pxck));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = !clk_sys_i;
  end
  task automatic chk(input logic [12:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
  endtask : rd
  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    s = {8{!v}};
    for (int k = 0; k < 3000 && s[b] !== v; k++) rd(`OFS_STAT, s);
    chk({12'h000, s[b]}, {12'h000, v});
  endtask : wait_st
  // Reference frame: start, data low bit first, parity, stops
  function automatic logic [12:0] frame(input int d, nb, pm, s2,
                                        output int n);
    logic [12:0] f;
    int p;
    f = '1;
    f[0] = 1'b0;
    p = (pm == 3) ? 1 : 0;
    for (int k = 0; k < nb; k++) begin
      f[k + 1] = d[k];
      p = p ^ d[k];
    end
    n = nb + 2 + s2 + ((pm >= 2) ? 1 : 0);
    if (pm >= 2) f[nb + 1] = p[0];
    return f;
  endfunction : frame
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Whole run needs at most about 11000 cycles; allow ample margin
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    errors++;
    test_done();
  end
  initial begin
    logic [7:0] r, s;
    logic [12:0] f, e;
    logic sy, ma, pol, dse, s2;
    int n, bc, d, nb, pm, dv, q, fl;
    int cz[6] = '{0, 1, 2, 3, 7, 3};
    int pt[6] = '{0, 2, 3, 1, 2, 3};
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    d = $urandom(32'h5f6eb870);
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), r);
      if (a != 4) chk({5'h0, r}, (a == 3) ? 13'h6 : 13'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      sy = i >= 4;
      ma = i == 4;
      pol = i == 5;
      s2 = 1'(i % 2);
      dse = s2 && !sy;
      nb = (cz[i] == 7) ? 9 : cz[i] + 5;
      pm = pt[i];
      dv = $urandom % 3 + (ma ? 4 : 0);
      bc = (dse ? 8 : 16) * (dv + 1);
      wr(`OFS_DIV_HI, 8'h00);
      wr(`OFS_DIV_LO, 8'(dv));
      rd(`OFS_DIV_LO, r);
      chk({5'h0, r}, 13'(dv));
      wr(`OFS_CTL_C, {sy, 2'(pm), s2, 3'(cz[i]), pol});
      d = $urandom % 512;
      wr(`OFS_CTL_A, {3'h0, ma, 2'h3, d[8], dse});
      e = frame(d, nb, pm, int'(s2), n);
      wr(`OFS_DATA, 8'(d));
      peer.grab(n, bc, sy, pol, f);
      chk(f, e & 13'((1 << n) - 1));
      wait_st(`S_BUSY, 1'b0);
      d = $urandom % 512;
      e = frame(d, nb, pm, int'(s2), n);
      q = nb + 1 + ((pm >= 2) ? 1 : 0);
      fl = (i == 1) ? nb + 1 : (i == 2) ? q : 13;
      if (fl < 13) e[fl] = !e[fl];
      peer.put(n, bc, sy, pol, e);
      wait_st(`S_FULL, 1'b1);
      rd(`OFS_STAT, s);
      rd(`OFS_DATA, r);
      d = d & ((1 << nb) - 1);
      chk({2'h0, s[`S_PE], s[`S_FE], s[`S_RX9], r},
          {2'h0, 1'(i == 1), 1'(i == 2), 9'(d)});
      // A low stop bit may look like a new start; let it pass
      repeat (2 * n * bc) @(posedge clk_sys_i);
      rd(`OFS_DATA, r);
      $display("test format %0d done", i);
    end
    test_done();
  end
endmodule : tb_usart_clock_and_frame_format

// ---- bench/usart_clock_and_frame_format_properties.sv ----
// Purpose: port-level checks of clock modes and bit timing
// Assumes: register map from the shared defines header
// Notes: shadows of mode, direction, speed and divisor
`timescale 1ns/1ps
`include "ucf_defines.svh"
module ucf_props (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial_receive_pin_i,
  input wire logic serial_transmit_pin_o,
  input wire logic transfer_clock_pin_i,
  input wire logic transfer_clock_pin_o,
  input wire logic transfer_clock_pin_oe_n_o
);
  logic ms_r, dir_r, dse_r;
  logic [11:0] div_r;
  logic [15:0] age_r, tcnt_r, xcnt_r;
  int per;
  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : sat
  assign per = (dse_r ? 8 : 16) * (int'(div_r) + 1);
  // Age gates out intervals that began before the last setup write
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ms_r <= 1'b0;
      dir_r <= 1'b0;
      dse_r <= 1'b0;
      div_r <= 12'h000;
      age_r <= 16'h0000;
      tcnt_r <= 16'h0000;
      xcnt_r <= 16'h0000;
    end else begin
      if (wr_i && addr_i == `OFS_CTL_C) ms_r <= wdata_i[`C_UMS];
      if (wr_i && addr_i == `OFS_CTL_A) dir_r <= wdata_i[`A_DIR];
      if (wr_i && addr_i == `OFS_CTL_A) dse_r <= wdata_i[`A_DSE];
      if (wr_i && addr_i == `OFS_DIV_LO) div_r[7:0] <= wdata_i;
      if (wr_i && addr_i == `OFS_DIV_HI) div_r[11:8] <= wdata_i[3:0];
      age_r <= (wr_i && addr_i < 3'h4) ? 16'h0000 : sat(age_r);
      tcnt_r <= $changed(serial_transmit_pin_o) ? 16'h0000 : sat(tcnt_r);
      xcnt_r <= $changed(transfer_clock_pin_o) ? 16'h0000 : sat(xcnt_r);
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_clk_pin_async: assert property (
    !ms_r && age_r > 16'h0002
    |-> transfer_clock_pin_oe_n_o && !transfer_clock_pin_o)
    else $error("clock pin active in async mode");
  a_clk_pin_master: assert property (
    ms_r && dir_r && age_r > 16'h0002 |-> !transfer_clock_pin_oe_n_o)
    else $error("clock pin not driven in master mode");
  a_clk_pin_slave: assert property (
    ms_r && !dir_r && age_r > 16'h0002
    |-> transfer_clock_pin_oe_n_o && !transfer_clock_pin_o)
    else $error("clock pin driven in slave mode");
  a_idle_after_reset: assert property (
    $rose(nrst_i) |-> serial_transmit_pin_o && transfer_clock_pin_oe_n_o)
    else $error("lines not idle after reset");
  a_div_hi_upper: assert property (
    rd_i && addr_i == `OFS_DIV_HI |=> rdata_o[7:4] == 4'h0)
    else $error("divisor high byte upper bits not zero");
  a_div_readback: assert property (
    wr_i && addr_i == `OFS_DIV_LO ##1 !wr_i && !rd_i
    ##1 rd_i && addr_i == `OFS_DIV_LO |=> rdata_o == $past(wdata_i, 3))
    else $error("divisor low byte read back wrong");
  a_master_half_bit: assert property (
    ms_r && dir_r && $changed(transfer_clock_pin_o)
    && int'(age_r) > int'(xcnt_r) + 4 |-> xcnt_r == {4'h0, div_r})
    else $error("master clock half period wrong");
  a_tx_bit_grid: assert property (
    !ms_r && $changed(serial_transmit_pin_o)
    && int'(age_r) > int'(tcnt_r) + 4 |-> (int'(tcnt_r) + 1) % per == 0)
    else $error("transmit edge off the bit grid");
  c_master_tog: cover property (ms_r && dir_r && $changed(transfer_clock_pin_o));
  c_tx_start: cover property ($fell(serial_transmit_pin_o));
  c_read: cover property (rd_i ##1 rdata_o != 8'h00);
endmodule : ucf_props
bind usart_clock_and_frame_format ucf_props u_props (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .serial_receive_pin_i(serial_receive_pin_i),
  .serial_transmit_pin_o(serial_transmit_pin_o),
  .transfer_clock_pin_i(transfer_clock_pin_i),
  .transfer_clock_pin_o(transfer_clock_pin_o),
  .transfer_clock_pin_oe_n_o(transfer_clock_pin_oe_n_o));

// ---- common/clk_evt_if.sv ----
// Purpose: timing events passed from the clock helpers to the port
// Assumes: all signals are one-cycle pulses on clk_sys_i, but baud_tick stays high while the divisor is 0
// Notes: none
`timescale 1ns/1ps
interface clk_evt_if;
  logic baud_tick;
  logic xck_rise;
  logic xck_fall;
  modport gen_mp(output baud_tick);
  modport edge_mp(output xck_rise, output xck_fall);
  modport use_mp(input baud_tick, input xck_rise, input xck_fall);
endinterface : clk_evt_if

// ---- common/ucf_defines.svh ----
// Purpose: named offsets, field positions, reset values and counts
// Assumes: included by the baud divider, the port top, the testbench and the properties file
// Notes: definitions only
`ifndef UCF_DEFINES_SVH
`define UCF_DEFINES_SVH

// Register offsets on the plain register port
`define OFS_DIV_LO 3'h0
`define OFS_DIV_HI 3'h1
`define OFS_CTL_A 3'h2
`define OFS_CTL_C 3'h3
`define OFS_DATA 3'h4
`define OFS_STAT 3'h5

// Control A fields
`define A_DSE 0
`define A_TX9 1
`define A_TXEN 2
`define A_RXEN 3
`define A_DIR 4

// Control C fields
`define C_POL 0
`define C_CSZ_LO 1
`define C_CSZ_HI 3
`define C_SBS 4
`define C_PM_LO 5
`define C_PM_HI 6
`define C_UMS 7

// Status fields
`define S_BUSY 0
`define S_FULL 1
`define S_FE 2
`define S_PE 3
`define S_RX9 4

// Reset values
`define RST_CTL_A 8'h00
`define RST_CTL_C 8'h06
`define RST_DIV_LO 8'h00
`define RST_DIV_HI 4'h0

// Divisor and frame geometry
`define DIV_W 12
`define DIV_HI_W 4
`define FRM_W 13
`define NB_MIN 4'h5
`define NB_DFLT 4'h8
`define NB_MAX 4'h9
`define CSZ_9 3'h7
`define CSZ_LAST_STD 3'h3
`define START_STOP 4'h2

// Samples per bit: last index and mid index, 16 or 8 samples
`define SMP_NRM_LAST 4'hf
`define SMP_DBL_LAST 4'h7
`define SMP_NRM_MID 4'h7
`define SMP_DBL_MID 4'h3

`endif

// ---- common/ucf_pkg.sv ----
// Purpose: state types of the serial port
// Assumes: nothing beyond the defines header
// Notes: one-hot codes written out
package ucf_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b100
  } rx_state_t;

endpackage : ucf_pkg

// ---- logic/baud_divider.sv ----
// Purpose: programmable down-counter making the baud tick
// Assumes: reload_i is a one-cycle pulse after a low-byte write
// Notes: tick rate is clock divided by divisor plus one
`timescale 1ns/1ps
`include "ucf_defines.svh"
module baud_divider #(
  parameter int W = `DIV_W
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] div_i,
  input wire logic reload_i,
  clk_evt_if.gen_mp ev
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    if (reload_i || cnt_r == '0) begin
      cnt_nxt = div_i;
    end else begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign ev.baud_tick = (cnt_r == '0);
endmodule : baud_divider

// ---- logic/usart_clock_and_frame_format.sv ----
// Purpose: clock modes, baud timing and frame format of a serial port
// Assumes: 40 MHz clk_sys_i, register port with one-cycle strobes
// Notes: no transmit buffer; a data write while busy is dropped
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "ucf_defines.svh"
module usart_clock_and_frame_format
  import ucf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic serial_receive_pin_i,
  output logic serial_transmit_pin_o,
  input wire logic transfer_clock_pin_i,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe_n_o
);

  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    if (csz == `CSZ_9) begin
      data_bits = `NB_MAX;
    end else if (csz <= `CSZ_LAST_STD) begin
      data_bits = `NB_MIN + {1'b0, csz};
    end else begin
      data_bits = `NB_DFLT;
    end
  endfunction : data_bits

  function automatic logic parity(input logic [8:0] d,
                                  input logic [3:0] nb,
                                  input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < nb) begin
        p = p ^ d[i];
      end
    end
    parity = p;
  endfunction : parity

  function automatic logic [8:0] mask_data(input logic [8:0] d,
                                           input logic [3:0] nb);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < nb) begin
        m[i] = d[i];
      end
    end
    mask_data = m;
  endfunction : mask_data

  clk_evt_if ev();

  // Register group
  logic [7:0] div_lo_r;
  logic [7:0] div_lo_nxt;
  logic [`DIV_HI_W-1:0] div_hi_r;
  logic [`DIV_HI_W-1:0] div_hi_nxt;
  logic [7:0] ctl_a_r;
  logic [7:0] ctl_a_nxt;
  logic [7:0] ctl_c_r;
  logic [7:0] ctl_c_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic reload_r;
  logic reload_nxt;
  logic xck_r;
  logic xck_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic [2:0] rxd_q_r;
  logic [2:0] rxd_q_nxt;
  logic rxd_r;
  logic rxd_nxt;

  // Transmit group
  tx_state_t tx_st_r;
  tx_state_t tx_st_nxt;
  logic [`FRM_W-1:0] tx_sh_r;
  logic [`FRM_W-1:0] tx_sh_nxt;
  logic [3:0] tx_left_r;
  logic [3:0] tx_left_nxt;
  logic [3:0] tx_pre_r;
  logic [3:0] tx_pre_nxt;
  logic tx_line_r;
  logic tx_line_nxt;

  // Receive group
  rx_state_t rx_st_r;
  rx_state_t rx_st_nxt;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_cnt_nxt;
  logic [3:0] rx_idx_r;
  logic [3:0] rx_idx_nxt;
  logic [10:0] rx_sh_r;
  logic [10:0] rx_sh_nxt;
  logic [8:0] rx_data_r;
  logic [8:0] rx_data_nxt;
  logic rx_full_r;
  logic rx_full_nxt;
  logic fe_r;
  logic fe_nxt;
  logic pe_r;
  logic pe_nxt;

  // Shared decoded settings
  logic sync_m;
  logic master;
  logic slave;
  logic dbl;
  logic pol;
  logic par_en;
  logic par_odd;
  logic two_stop;
  logic [3:0] nb;
  logic [3:0] smp_last;
  logic [3:0] smp_mid;
  logic tick;
  logic rise;
  logic fall;
  logic chg_ev;
  logic smp_ev;
  logic tx_bit_ev;
  logic tx_load;
  logic rx_done;

  assign sync_m = ctl_c_r[`C_UMS];
  assign master = sync_m & ctl_a_r[`A_DIR];
  assign slave = sync_m & ~ctl_a_r[`A_DIR];
  assign dbl = ctl_a_r[`A_DSE] & ~sync_m;
  assign pol = ctl_c_r[`C_POL];
  assign par_en = ctl_c_r[`C_PM_HI];
  assign par_odd = ctl_c_r[`C_PM_LO];
  assign two_stop = ctl_c_r[`C_SBS];
  assign nb = data_bits(ctl_c_r[`C_CSZ_HI:`C_CSZ_LO]);
  assign smp_last = dbl ? `SMP_DBL_LAST : `SMP_NRM_LAST;
  assign smp_mid = dbl ? `SMP_DBL_MID : `SMP_NRM_MID;
  // Divisor ticks are ignored in slave mode
  assign tick = ev.baud_tick & ~slave;
  assign rise = slave ? ev.xck_rise : (tick & master & ~xck_r);
  assign fall = slave ? ev.xck_fall : (tick & master & xck_r);
  assign chg_ev = pol ? fall : rise;
  assign smp_ev = pol ? rise : fall;
  assign tx_bit_ev = sync_m ? chg_ev
                            : (tick && tx_pre_r == smp_last);
  assign tx_load = wr_i && addr_i == `OFS_DATA && ctl_a_r[`A_TXEN]
                   && tx_st_r == TX_IDLE;

  baud_divider #(
    .W(`DIV_W)
  ) u_baud (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .div_i({div_hi_r, div_lo_r}),
    .reload_i(reload_r),
    .ev(ev.gen_mp)
  );

  xck_edge_sync u_xsync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .pin_i(transfer_clock_pin_i),
    .ev(ev.edge_mp)
  );

  // Register port, clock pin and receive pin synchroniser
  always_comb begin
    div_lo_nxt = div_lo_r;
    div_hi_nxt = div_hi_r;
    ctl_a_nxt = ctl_a_r;
    ctl_c_nxt = ctl_c_r;
    rdata_nxt = 8'h00;
    reload_nxt = wr_i && addr_i == `OFS_DIV_LO;
    if (wr_i) begin
      case (addr_i)
        `OFS_DIV_LO: div_lo_nxt = wdata_i;
        `OFS_DIV_HI: div_hi_nxt = wdata_i[`DIV_HI_W-1:0];
        `OFS_CTL_A: ctl_a_nxt = wdata_i;
        `OFS_CTL_C: ctl_c_nxt = wdata_i;
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `OFS_DIV_LO: rdata_nxt = div_lo_r;
        `OFS_DIV_HI: rdata_nxt = {4'h0, div_hi_r};
        `OFS_CTL_A: rdata_nxt = ctl_a_r;
        `OFS_CTL_C: rdata_nxt = ctl_c_r;
        `OFS_DATA: rdata_nxt = rx_data_r[7:0];
        `OFS_STAT: begin
          rdata_nxt[`S_BUSY] = tx_st_r != TX_IDLE;
          rdata_nxt[`S_FULL] = rx_full_r;
          rdata_nxt[`S_FE] = fe_r;
          rdata_nxt[`S_PE] = pe_r;
          rdata_nxt[`S_RX9] = rx_data_r[8];
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Master toggles once per tick, so one bit spans two ticks
    xck_nxt = master ? (xck_r ^ tick) : 1'b0;
    oe_n_nxt = ~master;
    rxd_q_nxt = {rxd_q_r[1:0], serial_receive_pin_i};
    rxd_nxt = (rxd_q_r[1] == rxd_q_r[2]) ? rxd_q_r[2] : rxd_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_lo_r <= `RST_DIV_LO;
      div_hi_r <= `RST_DIV_HI;
      ctl_a_r <= `RST_CTL_A;
      ctl_c_r <= `RST_CTL_C;
      rdata_r <= 8'h00;
      reload_r <= 1'b0;
      xck_r <= 1'b0;
      oe_n_r <= 1'b1;
      rxd_q_r <= 3'h7;
      rxd_r <= 1'b1;
    end else begin
      div_lo_r <= div_lo_nxt;
      div_hi_r <= div_hi_nxt;
      ctl_a_r <= ctl_a_nxt;
      ctl_c_r <= ctl_c_nxt;
      rdata_r <= rdata_nxt;
      reload_r <= reload_nxt;
      xck_r <= xck_nxt;
      oe_n_r <= oe_n_nxt;
      rxd_q_r <= rxd_q_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  // Transmitter
  always_comb begin
    logic [`FRM_W-1:0] frm;
    logic [8:0] d;
    frm = '1;
    d = {ctl_a_r[`A_TX9], wdata_i};
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_left_nxt = tx_left_r;
    tx_pre_nxt = tx_pre_r;
    tx_line_nxt = tx_line_r;
    if (tick && !sync_m) begin
      tx_pre_nxt = (tx_pre_r == smp_last) ? 4'h0 : tx_pre_r + 4'h1;
    end
    frm[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < nb) begin
        frm[1 + i] = d[i];
      end
    end
    if (par_en) begin
      frm[1 + nb] = parity(d, nb, par_odd);
    end
    case (tx_st_r)
      TX_IDLE: begin
        tx_line_nxt = 1'b1;
        if (tx_load) begin
          tx_sh_nxt = frm;
          tx_left_nxt = `START_STOP + nb + {3'h0, par_en}
                        + {3'h0, two_stop};
          tx_st_nxt = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tx_bit_ev) begin
          if (tx_left_r != 4'h0) begin
            tx_line_nxt = tx_sh_r[0];
            tx_sh_nxt = {1'b1, tx_sh_r[`FRM_W-1:1]};
            tx_left_nxt = tx_left_r - 4'h1;
          end else begin
            // Last stop bit has had its full bit time
            tx_line_nxt = 1'b1;
            tx_st_nxt = TX_IDLE;
          end
        end
      end
      default: begin
        tx_st_nxt = TX_IDLE;
        tx_line_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= '1;
      tx_left_r <= 4'h0;
      tx_pre_r <= 4'h0;
      tx_line_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_left_r <= tx_left_nxt;
      tx_pre_r <= tx_pre_nxt;
      tx_line_r <= tx_line_nxt;
    end
  end

  // Receiver
  always_comb begin
    logic [10:0] shv;
    logic take;
    shv = rx_sh_r;
    take = 1'b0;
    rx_st_nxt = rx_st_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_idx_nxt = rx_idx_r;
    rx_sh_nxt = rx_sh_r;
    rx_data_nxt = rx_data_r;
    fe_nxt = fe_r;
    pe_nxt = pe_r;
    rx_done = 1'b0;
    case (rx_st_r)
      RX_IDLE: begin
        rx_cnt_nxt = 4'h0;
        rx_idx_nxt = 4'h0;
        if (ctl_a_r[`A_RXEN] && !rxd_r) begin
          if (sync_m && smp_ev) begin
            rx_st_nxt = RX_DATA;
          end else if (!sync_m && tick) begin
            rx_st_nxt = RX_START;
          end
        end
      end
      RX_START: begin
        if (tick) begin
          if (rx_cnt_r == smp_mid) begin
            // A short low pulse is a false start
            rx_st_nxt = rxd_r ? RX_IDLE : RX_DATA;
            rx_cnt_nxt = 4'h0;
          end else begin
            rx_cnt_nxt = rx_cnt_r + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (sync_m) begin
          take = smp_ev;
        end else if (tick) begin
          take = rx_cnt_r == smp_last;
          rx_cnt_nxt = take ? 4'h0 : rx_cnt_r + 4'h1;
        end
        if (take) begin
          shv[rx_idx_r] = rxd_r;
          rx_sh_nxt = shv;
          rx_idx_nxt = rx_idx_r + 4'h1;
          if (rx_idx_r == nb + {3'h0, par_en}) begin
            // Back to idle on the first stop bit
            rx_done = 1'b1;
            rx_st_nxt = RX_IDLE;
            fe_nxt = ~rxd_r;
            pe_nxt = par_en
                     && shv[nb] != parity(shv[8:0], nb, par_odd);
            rx_data_nxt = mask_data(shv[8:0], nb);
          end
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    // A frame finishing in the reading cycle keeps the flag set
    if (rx_done) begin
      rx_full_nxt = 1'b1;
    end else if (rd_i && addr_i == `OFS_DATA) begin
      rx_full_nxt = 1'b0;
    end else begin
      rx_full_nxt = rx_full_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 11'h000;
      rx_data_r <= 9'h000;
      rx_full_r <= 1'b0;
      fe_r <= 1'b0;
      pe_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_data_r <= rx_data_nxt;
      rx_full_r <= rx_full_nxt;
      fe_r <= fe_nxt;
      pe_r <= pe_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign serial_transmit_pin_o = tx_line_r;
  assign transfer_clock_pin_o = xck_r;
  assign transfer_clock_pin_oe_n_o = oe_n_r;
endmodule : usart_clock_and_frame_format

// ---- logic/xck_edge_sync.sv ----
// Purpose: synchronise the external transfer clock and find its edges
// Assumes: external clock below a quarter of clk_sys_i
// Notes: a level counts once the second and third stages agree
`timescale 1ns/1ps
module xck_edge_sync (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  clk_evt_if.edge_mp ev
);
  logic [2:0] q_r;
  logic [2:0] q_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic rise_r;
  logic rise_nxt;
  logic fall_r;
  logic fall_nxt;

  always_comb begin
    q_nxt = {q_r[1:0], pin_i};
    lvl_nxt = lvl_r;
    rise_nxt = 1'b0;
    fall_nxt = 1'b0;
    // First stage q_r[0] feeds only the second stage
    if (q_r[1] == q_r[2] && q_r[2] != lvl_r) begin
      lvl_nxt = q_r[2];
      rise_nxt = q_r[2];
      fall_nxt = ~q_r[2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      q_r <= 3'h0;
      lvl_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign ev.xck_rise = rise_r;
  assign ev.xck_fall = fall_r;
endmodule : xck_edge_sync
